// ==== qdw_pkg.sv ====
/*
 Package for the queued write command block: the opcode, field positions,
 status and error bit positions, timing counts and carrier structs.
 Assumes a 100 MHz clock.
*/
`default_nettype none
package qdw_pkg;
	localparam logic [7:0]  QDW_OPC_QWRITE   = 8'h61;
	localparam int          QDW_TAG_LSB      = 3;
	localparam int          QDW_PRIO_LSB     = 6;
	localparam int          QDW_FUA_BIT      = 7;
	localparam int          QDW_LBA_MODE_BIT = 6;
	localparam int          QDW_DEV_BIT      = 4;
	localparam int          QDW_ICC_COARSE   = 7;
	localparam logic [1:0]  QDW_PRIO_NORM    = 2'h0;
	localparam logic [1:0]  QDW_PRIO_ISO     = 2'h1;
	localparam logic [1:0]  QDW_PRIO_HIGH    = 2'h2;
	// Status bit positions
	localparam int          QDW_ST_BSY = 7;
	localparam int          QDW_ST_RDY = 6;
	localparam int          QDW_ST_DF  = 5;
	localparam int          QDW_ST_DSC = 4;
	localparam int          QDW_ST_COR = 2;
	localparam int          QDW_ST_ERR = 0;
	// Error bit positions
	localparam int          QDW_ER_CRC = 7;
	localparam int          QDW_ER_IDN = 4;
	localparam int          QDW_ER_ABT = 2;
	localparam logic [7:0]  QDW_STATUS_RST = 8'h00;
	// Timing
	localparam int          QDW_CLK_MHZ    = 100;
	localparam int          QDW_FINE_MS    = 10;
	localparam int          QDW_COARSE_MS  = 500;
	localparam int          QDW_FINE_CYC   = QDW_FINE_MS * 1000 * QDW_CLK_MHZ;
	localparam int          QDW_COARSE_CYC = QDW_COARSE_MS * 1000 * QDW_CLK_MHZ;

	typedef struct packed {
		logic [7:0] feat_cur;
		logic [7:0] feat_prev;
		logic [7:0] scnt_cur;
		logic [7:0] scnt_prev;
		logic [7:0] snum_cur;
		logic [7:0] snum_prev;
		logic [7:0] cyl_lo_cur;
		logic [7:0] cyl_lo_prev;
		logic [7:0] cyl_hi_cur;
		logic [7:0] cyl_hi_prev;
		logic [7:0] dev_head;
		logic [7:0] opcode;
	} qdw_cmd_block_s;

	typedef struct packed {
		logic [4:0]  tag;
		logic [1:0]  prio;
		logic [47:0] lba;
		logic [16:0] count;
		logic        fua;
		logic        iso;
		logic        coarse;
		logic [6:0]  limit;
	} qdw_cmd_s;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] error;
		logic [4:0] tag;
	} qdw_done_s;
endpackage
`default_nettype wire

// ==== qdw_top.sv ====
/*
 Queued first-party DMA write command engine: decodes the command block,
 queues commands, picks by priority and deadline, buffers host words
 through a two-entry skid, writes to media and reports completion.
 Assumes the host keeps tags unique and inside the reported depth, and
 that a media model answers each word write with ack or an error.
*/
// Contract
// - Opcode 61h selects queued DMA write
// - Move host sectors, then write media
// - Feature bytes carry sector count
// - High first; iso before deadline
// - Deadline field used only for iso
// - Fine deadline: (n+1) times 10 ms
// - Coarse deadline: (n+1) times 0.5 s; code wraps the 32-bit cycle count for n above 84
// - Expired commands still complete promptly
// - Abort on deadline only when enabled
// - FUA completes only after media write
// - Cached write may complete early
// - Stop at first failing sector; code ignores media errors on cached non-FUA writes
// - Report 48-bit failing LBA, HOB select
`timescale 1ns/10ps
`default_nettype none
module qdw_top
	import qdw_pkg::*;
#(
	parameter int DEPTH     = 32,
	parameter int FINE_CYC  = QDW_FINE_CYC,
	parameter int COARSE_CYC = QDW_COARSE_CYC
)(
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic           cmd_valid,
	input  wire qdw_cmd_block_s cmd_blk,
	output logic                cmd_ready,
	input  wire logic           wcache_en,
	input  wire logic           dl_abort_en,
	input  wire logic           hob,
	input  wire logic           hdata_valid,
	input  wire logic [15:0]    hdata,
	output logic                hdata_ready,
	output logic                media_valid,
	output logic [15:0]         media_data,
	output logic [47:0]         media_lba,
	input  wire logic           media_ack,
	input  wire logic           media_err,
	output logic                done_valid,
	output qdw_done_s           done,
	output logic [23:0]         err_lba_out,
	output logic                busy
);
	localparam int SEC_WORDS = 256;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire logic rn = rst_s2_q;

	// ----------------------------------------
	// Decode and queue
	// ----------------------------------------
	qdw_cmd_s   q_cmd_q   [DEPTH];
	logic [31:0] q_dl_q   [DEPTH];
	logic [DEPTH-1:0] q_vld_q;
	qdw_cmd_s   dec;
	logic       is_cmd;

	always_comb begin
		dec.tag    = cmd_blk.scnt_cur[7:QDW_TAG_LSB];
		dec.prio   = cmd_blk.scnt_prev[7:QDW_PRIO_LSB];
		dec.lba    = {cmd_blk.cyl_hi_prev, cmd_blk.cyl_lo_prev, cmd_blk.snum_prev,
			cmd_blk.cyl_hi_cur, cmd_blk.cyl_lo_cur, cmd_blk.snum_cur};
		// Zero count means 65536 sectors
		dec.count  = {({cmd_blk.feat_prev, cmd_blk.feat_cur} == 16'h0000),
			cmd_blk.feat_prev, cmd_blk.feat_cur};
		dec.fua    = cmd_blk.dev_head[QDW_FUA_BIT];
		dec.iso    = (dec.prio == QDW_PRIO_ISO);
		dec.coarse = cmd_blk.feat_prev[QDW_ICC_COARSE];
		dec.limit  = cmd_blk.feat_prev[6:0];
	end

	assign is_cmd = cmd_valid && cmd_ready && cmd_blk.opcode == QDW_OPC_QWRITE;

	// ----------------------------------------
	// Scheduler: high, then earliest iso deadline, then normal
	// ----------------------------------------
	typedef enum logic [1:0] {QDW_IDLE, QDW_XFER, QDW_DONE} qdw_state_e;
	qdw_state_e st_q;
	logic [4:0] cur_q;
	logic [4:0] pick;
	logic       pick_ok;
	always_comb begin
		pick = 5'h00;
		pick_ok = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			if (q_vld_q[i] && !pick_ok && q_cmd_q[i].prio == QDW_PRIO_HIGH) begin
				pick = 5'(i);
				pick_ok = 1'b1;
			end
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (q_vld_q[i] && q_cmd_q[i].iso && (!pick_ok ||
				(q_cmd_q[pick].iso && q_dl_q[i] < q_dl_q[pick]))) begin
				pick = 5'(i);
				pick_ok = 1'b1;
			end
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (q_vld_q[i] && !pick_ok) begin
				pick = 5'(i);
				pick_ok = 1'b1;
			end
		end
	end

	// Deadline countdown in cycles; saturates at zero when expired
	logic [31:0] dl_init;
	always_comb begin
		if (!dec.coarse)
			dl_init = 32'(({1'b0, dec.limit} + 8'h01) * FINE_CYC);
		else
			dl_init = 32'(({1'b0, dec.limit} + 8'h01) * COARSE_CYC);
		if (!dec.iso)
			dl_init = 32'hffffffff;
	end

	logic [DEPTH-1:0] expired;
	logic             abort_hit;
	always_comb begin
		abort_hit = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			expired[i] = q_cmd_q[i].iso && q_dl_q[i] == 32'h0;
		end
		// Wait for the word in flight so the media handshake is never cut
		if (st_q == QDW_XFER && dl_abort_en && expired[cur_q] && !media_valid)
			abort_hit = 1'b1;
	end

	// ----------------------------------------
	// Two-entry skid buffer on host data
	// ----------------------------------------
	logic [15:0] buf_q [2];
	logic [1:0]  buf_cnt_q;
	logic        buf_rd_q;
	logic        buf_wr_q;
	logic        take_in, take_out;
	logic [24:0] in_left_q;
	assign take_in  = hdata_valid && hdata_ready;
	assign take_out = buf_cnt_q != 2'h0 && st_q == QDW_XFER && !media_valid;
	always_ff @(posedge clk or negedge rn) begin
		if (!rn) begin
			buf_cnt_q   <= 2'h0;
			buf_rd_q    <= 1'b0;
			buf_wr_q    <= 1'b0;
			hdata_ready <= 1'b0;
			in_left_q   <= 25'h0;
			buf_q[0]    <= 16'h0000;
			buf_q[1]    <= 16'h0000;
		end else begin
			// Leftovers of a stopped command must not leak into the next one
			if (st_q == QDW_IDLE && pick_ok) begin
				buf_cnt_q <= 2'h0;
				buf_rd_q  <= 1'b0;
				buf_wr_q  <= 1'b0;
				in_left_q <= {q_cmd_q[pick].count, 8'h00};
			end else begin
				if (take_in) begin
					buf_q[buf_wr_q] <= hdata;
					buf_wr_q  <= ~buf_wr_q;
					in_left_q <= in_left_q - 25'h1;
				end
				if (take_out)
					buf_rd_q <= ~buf_rd_q;
				buf_cnt_q <= buf_cnt_q + 2'(take_in) - 2'(take_out);
			end
			hdata_ready <= st_q == QDW_XFER && in_left_q != 25'(take_in) &&
				(buf_cnt_q + 2'(take_in) - 2'(take_out)) == 2'h0;
		end
	end

	// ----------------------------------------
	// Transfer, media and completion
	// ----------------------------------------
	logic [16:0] sec_left_q;
	logic [7:0]  word_q;
	logic [47:0] lba_q;
	logic        failed_q;
	logic        fua_cur_q;
	logic        aborted_q;
	logic [47:0] err_lba_q;
	always_ff @(posedge clk or negedge rn) begin
		if (!rn) begin
			st_q        <= QDW_IDLE;
			cur_q       <= 5'h00;
			sec_left_q  <= 17'h00000;
			word_q      <= 8'h00;
			lba_q       <= 48'h0;
			failed_q    <= 1'b0;
			fua_cur_q   <= 1'b0;
			aborted_q   <= 1'b0;
			err_lba_q   <= 48'h0;
			media_valid <= 1'b0;
			media_data  <= 16'h0000;
			media_lba   <= 48'h0;
			done_valid  <= 1'b0;
			done        <= '0;
			busy        <= 1'b0;
		end else begin
			done_valid <= 1'b0;
			case (st_q)
			QDW_IDLE: begin
				if (pick_ok) begin
					st_q       <= QDW_XFER;
					cur_q      <= pick;
					sec_left_q <= q_cmd_q[pick].count;
					lba_q      <= q_cmd_q[pick].lba;
					word_q     <= 8'h00;
					failed_q   <= 1'b0;
					aborted_q  <= 1'b0;
					fua_cur_q  <= q_cmd_q[pick].fua;
					busy       <= 1'b1;
				end
			end
			QDW_XFER: begin
				if (take_out) begin
					media_valid <= 1'b1;
					media_data  <= buf_q[buf_rd_q];
					media_lba   <= lba_q;
				end
				// Cached writes are acked at once; FUA waits for media
				if (media_valid && (media_ack || media_err ||
					(wcache_en && !fua_cur_q))) begin
					media_valid <= 1'b0;
					if (media_err && !(wcache_en && !fua_cur_q)) begin
						failed_q  <= 1'b1;
						err_lba_q <= lba_q;
						st_q      <= QDW_DONE;
					end else if (word_q == 8'(SEC_WORDS - 1)) begin
						word_q     <= 8'h00;
						lba_q      <= lba_q + 48'h1;
						sec_left_q <= sec_left_q - 17'h1;
						if (sec_left_q == 17'h1)
							st_q <= QDW_DONE;
					end else begin
						word_q <= word_q + 8'h01;
					end
				end
				if (abort_hit) begin
					media_valid <= 1'b0;
					aborted_q   <= 1'b1;
					st_q        <= QDW_DONE;
				end
			end
			QDW_DONE: begin
				done_valid <= 1'b1;
				done.tag   <= cur_q;
				done.status <= QDW_STATUS_RST | (8'h01 << QDW_ST_RDY) | (8'h01 << QDW_ST_DSC)
					| (8'(failed_q || aborted_q) << QDW_ST_ERR);
				done.error  <= failed_q ? (8'h01 << QDW_ER_IDN) :
					(aborted_q ? (8'h01 << QDW_ER_ABT) : 8'h00);
				busy <= 1'b0;
				st_q <= QDW_IDLE;
			end
			default: st_q <= QDW_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Queue storage and deadline timers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rn) begin
		if (!rn) begin
			q_vld_q   <= '0;
			cmd_ready <= 1'b0;
			for (int i = 0; i < DEPTH; i++) begin
				q_cmd_q[i] <= '0;
				q_dl_q[i]  <= 32'h0;
			end
		end else begin
			cmd_ready <= ~&q_vld_q;
			for (int i = 0; i < DEPTH; i++) begin
				// Expired ones stay queued and stop at zero; other iso ones keep running
				// The running command keeps its timer going as well
				if ((q_vld_q[i] || (st_q == QDW_XFER && cur_q == 5'(i))) &&
					q_dl_q[i] != 32'h0 && q_cmd_q[i].iso)
					q_dl_q[i] <= q_dl_q[i] - 32'h1;
			end
			if (st_q == QDW_IDLE && pick_ok)
				q_vld_q[pick] <= 1'b0;
			if (is_cmd && 32'(dec.tag) < DEPTH) begin
				q_cmd_q[dec.tag] <= dec;
				q_dl_q[dec.tag]  <= dl_init;
				q_vld_q[dec.tag] <= 1'b1;
			end
		end
	end

	// HOB picks the high or low half of the failing address
	always_ff @(posedge clk or negedge rn) begin
		if (!rn)
			err_lba_out <= 24'h000000;
		else
			err_lba_out <= hob ? err_lba_q[47:24] : err_lba_q[23:0];
	end
endmodule // qdw_top
`default_nettype wire

// ==== qdw_checker.sv ====
/* Port assertions for qdw_top.
 Bound to qdw_top below; needs qdw_pkg. */
`timescale 1ns/10ps
`default_nettype none
module qdw_checker
	import qdw_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        wcache_en,
	input wire logic        hdata_ready,
	input wire logic        media_valid,
	input wire logic [15:0] media_data,
	input wire logic [47:0] media_lba,
	input wire logic        media_ack,
	input wire logic        media_err,
	input wire logic        done_valid,
	input wire qdw_done_s   done,
	input wire logic        busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------
	// Completion
	// ----------------
	AST_DONE_CLEAN: assert property (done_valid |-> !done.status[QDW_ST_BSY] && !done.status[QDW_ST_DF] &&
		!done.status[QDW_ST_COR]) else $error("busy, fault or corrected set at done");
	AST_ERR_BITS: assert property (done_valid |-> (done.error & 8'h6b) == 8'h00)
		else $error("illegal error bit at done");
	AST_ERR_SUM: assert property (done_valid |-> done.status[QDW_ST_ERR] == (done.error != 8'h00))
		else $error("error flag disagrees with error byte");
	AST_DONE_PULSE: assert property (done_valid |=> !done_valid) else $error("done longer than one cycle");
	AST_DONE_WAS_BUSY: assert property (done_valid |-> $past(busy)) else $error("done without a command");
	AST_READY_BUSY: assert property (hdata_ready |-> busy) else $error("host data taken while idle");
	// ----------------
	// Media side
	// ----------------
	AST_HOLD_UNCACHED: assert property (media_valid && !wcache_en && !media_ack && !media_err |=>
		media_valid && $stable(media_lba) && $stable(media_data)) else $error("media write dropped early");
	AST_NO_MORE_WRITE: assert property (media_valid && media_err && !wcache_en |=> !media_valid [*4])
		else $error("write went on after failure");
	AST_STOP_ON_ERR: assert property (media_valid && media_err && !wcache_en |-> ##[1:600] done_valid &&
		done.error[QDW_ER_IDN]) else $error("failure not reported");
	cover property (done_valid && done.error[QDW_ER_ABT]);
	cover property (media_valid && media_err);
	cover property (done_valid && done.error == 8'h00);
endmodule // qdw_checker
bind qdw_top qdw_checker chk (.clk(clk), .rst_b(rst_b), .wcache_en(wcache_en), .hdata_ready(hdata_ready),
	.media_valid(media_valid), .media_data(media_data), .media_lba(media_lba), .media_ack(media_ack),
	.media_err(media_err), .done_valid(done_valid), .done(done), .busy(busy));
`default_nettype wire

// ==== qdw_media_model.sv ====
/* Disk media model: answers each word write with ack, or err at one LBA.
 Driven by the bench; slow adds wait cycles. */
`timescale 1ns/10ps
`default_nettype none
module qdw_media_model (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        slow,
	input wire logic        err_en,
	input wire logic [47:0] err_lba,
	input wire logic        media_valid,
	input wire logic [47:0] media_lba,
	output logic            media_ack,
	output logic            media_err
);
	logic [1:0] wait_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q <= 2'h0;
			media_ack <= 1'b0;
			media_err <= 1'b0;
		end else begin
			media_ack <= 1'b0;
			media_err <= 1'b0;
			// One answer per word: skip the cycle that carries the last one
			if (media_valid && !media_ack && !media_err) begin
				if (wait_q >= (slow ? 2'h3 : 2'h0)) begin
					wait_q <= 2'h0;
					if (err_en && media_lba == err_lba)
						media_err <= 1'b1;
					else
						media_ack <= 1'b1;
				end else
					wait_q <= wait_q + 2'h1;
			end
		end
	end
endmodule // qdw_media_model
`default_nettype wire

// ==== queued_dma_write_command_bench.sv ====
/* Self-checking bench for qdw_top acting as host.
 Needs qdw_pkg, qdw_media_model and qdw_checker. */
`timescale 1ns/10ps
`default_nettype none
module queued_dma_write_command_bench
	import qdw_pkg::*;
;
	logic clk = 0, rst_b = 0, cmd_valid = 0, wcache_en = 0, dl_abort_en = 0, hob = 0, hdata_valid = 0;
	logic slow = 0, err_en = 0, chk = 0, acc = 0, cmd_ready, hdata_ready, media_valid, media_ack;
	logic media_err, done_valid, busy;
	logic [15:0] hdata = 16'h0000, media_data;
	logic [47:0] err_lba = 48'h0, lba = 48'h0, media_lba;
	logic [31:0] rs = 32'hd627;
	logic [23:0] err_lba_out;
	logic [12:0] e;
	qdw_cmd_block_s cmd_blk = '0;
	qdw_done_s done;
	int errors = 0, checks = 0;
	logic [12:0] notes[$];
	logic [15:0] words[$];
	always #5 clk = ~clk;
	qdw_top #(.FINE_CYC(10), .COARSE_CYC(50)) uut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_blk(cmd_blk), .cmd_ready(cmd_ready), .wcache_en(wcache_en), .dl_abort_en(dl_abort_en), .hob(hob),
		.hdata_valid(hdata_valid), .hdata(hdata), .hdata_ready(hdata_ready), .media_valid(media_valid),
		.media_data(media_data), .media_lba(media_lba), .media_ack(media_ack), .media_err(media_err),
		.done_valid(done_valid), .done(done), .err_lba_out(err_lba_out), .busy(busy));
	qdw_media_model media (.clk(clk), .rst_b(rst_b), .slow(slow), .err_en(err_en), .err_lba(err_lba),
		.media_valid(media_valid), .media_lba(media_lba), .media_ack(media_ack), .media_err(media_err));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic send(input logic [4:0] tag, input logic [1:0] pr, input logic fua, input logic [7:0] opc);
		int n;
		@(negedge clk);
		cmd_blk = '{8'h01, 8'h00, {tag, 3'h0}, {pr, 6'h00}, lba[7:0], lba[31:24], lba[15:8], lba[39:32],
			lba[23:16], lba[47:40], {fua, 7'h40}, opc};
		cmd_valid = 1'b1;
		for (n = 0; n < 2000 && cmd_ready !== 1'b1; n++)
			@(negedge clk);
		@(negedge clk) cmd_valid = 1'b0;
	endtask
	task automatic idle;
		int n;
		for (n = 0; n < 8000 && (notes.size() > 0 || busy !== 1'b0); n++)
			@(negedge clk);
		if (n == 8000) begin
			errors++;
			$display("MISMATCH %0t hang", $time);
			wrap_up;
		end
	endtask
	// ----------------
	// Host words and result watch
	// ----------------
	always @(negedge clk) if (acc) begin
		rs = xs(rs);
		hdata = rs[15:0];
	end
	always @(posedge clk) begin
		acc = hdata_valid && hdata_ready;
		if (acc && chk)
			words.push_back(hdata);
		if (media_valid && media_ack && chk && words.size() > 0)
			cmp(media_data, words.pop_front(), "media word");
		if (done_valid === 1'b1) begin
			if (notes.size() == 0)
				cmp(1, 0, "unexpected done");
			else begin
				e = notes.pop_front();
				cmp({done.tag, done.error}, e, "done tag or error");
				cmp(done.status[QDW_ST_ERR], |e[7:0], "error flag");
			end
		end
	end
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		repeat (3) @(negedge clk);
		hdata_valid = 1'b1;
		chk = 1'b1;
		rs = xs(rs);
		lba = {rs[15:0], rs};
		notes.push_back({5'd1, 8'h00});
		send(5'd1, QDW_PRIO_NORM, 1'b0, QDW_OPC_QWRITE);
		send(5'd9, QDW_PRIO_NORM, 1'b0, 8'h35);
		idle;
		chk = 1'b0;
		cmp(words.size(), 0, "words lost");
		slow = 1'b1;
		notes = '{13'h0200, 13'h0400, 13'h0300};
		send(5'd2, QDW_PRIO_NORM, 1'b0, QDW_OPC_QWRITE);
		send(5'd3, QDW_PRIO_NORM, 1'b0, QDW_OPC_QWRITE);
		send(5'd4, QDW_PRIO_HIGH, 1'b0, QDW_OPC_QWRITE);
		idle;
		slow = 1'b0;
		err_en = 1'b1;
		err_lba = lba;
		notes.push_back({5'd5, 8'h10});
		send(5'd5, QDW_PRIO_NORM, 1'b0, QDW_OPC_QWRITE);
		idle;
		repeat (2) @(negedge clk);
		cmp(err_lba_out, err_lba[23:0], "low failing address");
		hob = 1'b1;
		repeat (2) @(negedge clk);
		cmp(err_lba_out, err_lba[47:24], "high failing address");
		wcache_en = 1'b1;
		for (int f = 0; f < 2; f++) begin
			lba = lba + 48'h8;
			err_lba = lba;
			notes.push_back({5'd6, f ? 8'h10 : 8'h00});
			send(5'd6, QDW_PRIO_NORM, f[0], QDW_OPC_QWRITE);
			idle;
		end
		wcache_en = 1'b0;
		err_en = 1'b0;
		slow = 1'b1;
		for (int k = 0; k < 3; k++) begin
			dl_abort_en = k > 0;
			notes.push_back({5'd7, k == 1 ? 8'h04 : 8'h00});
			send(5'd7, k == 2 ? QDW_PRIO_NORM : QDW_PRIO_ISO, 1'b0, QDW_OPC_QWRITE);
			idle;
		end
		wrap_up;
	end
endmodule // queued_dma_write_command_bench
`default_nettype wire
